// ---- verilog/lsa_pkg.sv ----
// constants and carriers for the low-power dram command block
// assumes one 40 mhz clock domain in the device logic
`default_nettype none
package lsa_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_EXT = 8'h04;
  localparam logic [7:0] REG_TEMP = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int EMR_PARTIAL_ARRAY_REFRESH_SELECT_LSB = 0;
  localparam int EMR_DS_LSB = 5;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] BL_RST = 3'h2;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_RST = 3'h0;
  localparam logic [1:0] DS_RST = 2'h0;
  localparam logic [3:0] TEMP_RST = 4'h1;
  // ---------------------------------------------------------------
  // bank selects, burst and drive figures
  // ---------------------------------------------------------------
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_SRR = 2'h1;
  localparam logic [1:0] BA_EMR = 2'h2;
  localparam logic [4:0] SRR_LEN = 5'h02;
  localparam logic [5:0] OHM_FULL = 6'd25;
  localparam logic [5:0] OHM_3Q = 6'd37;
  localparam logic [5:0] OHM_HALF = 6'd55;
  localparam int PIPE_N = 3;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP, CMD_LMR, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_BST,
    CMD_REF
  } lsa_cmd_t;
  typedef struct packed {
    logic ck;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [1:0] ba;
    logic [12:0] addr;
  } lsa_pins_t;
  typedef struct packed {
    logic vld;
    logic stop;
    logic all_bk;
    logic [1:0] bank;
    logic [3:0] col;
    logic ap;
    logic status_read_word;
    logic [4:0] len;
  } lsa_ent_t;
endpackage
`default_nettype wire

// ---- verilog/lsa_dram.sv ----
// command decode, mode settings and read burst path of the dram
// assumes controller pins are stable around each ck rising edge
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: temp refresh bits ignored, sensor paces refresh
// RULE2: partial refresh picks one of five regions
// RULE3: reads reach whole array regardless of region
// RULE4: drive strength selects 25, 37, 55 ohms
// RULE5: status read starts with lmr ba 01
// RULE6: status read only when all banks idle
// RULE7: only nop during status setup, then read
// RULE8: only nop during status completion delay
// RULE9: status returns two beats, first valid
// RULE10: status word holds maker, revision, multiplier, size
// RULE11: controller scales refresh interval by multiplier
// RULE12: activate row before column command
// RULE13: precharge before reopen, honour row cycle
// RULE14: space activates across banks
// RULE15: auto precharge closes row after burst
// RULE16: first data after latency, then every edge
// RULE17: strobe preamble, postamble, then data floats
// RULE18: read cut by read, write, stop, precharge
// RULE19: later read concatenates or truncates seamlessly
// RULE20: burst stop acts after read latency
// RULE21: controller ends read before write
// RULE22: precharge x cycles after read truncates
// RULE23: read latency programmable two or three
// RULE24: extended mode loaded by lmr ba 10
module lsa_dram import lsa_pkg::*; #(
  parameter logic [3:0] MAKER_ID = 4'h5, // arbitrary value
  parameter logic [3:0] REV_ID = 4'h1, // arbitrary value
  parameter logic [2:0] DENSITY = 3'h3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // dram command pins
  input wire logic ck_i,
  input wire logic cs_b_i,
  input wire logic ras_b_i,
  input wire logic cas_b_i,
  input wire logic we_b_i,
  input wire logic [1:0] ba_i,
  input wire logic [12:0] addr_i,
  // dram data pins
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe_o,
  // self refresh settings and drive impedance
  output logic [3:0] sref_bank_o,
  output logic [1:0] sref_row_zero_o,
  output logic [3:0] sref_rate_o,
  output logic [5:0] drive_ohms_o
);
  // ---------------------------------------------------------------
  // pin synchroniser and filter
  // ---------------------------------------------------------------
  lsa_pins_t s1_reg, s2_reg, s3_reg, pin_reg;
  logic ck_d_reg;
  logic rise, fall;
  lsa_cmd_t cmd;

  // three stages, accept once second and third agree
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_reg <= '0;
      ck_d_reg <= 1'b0;
    end else begin
      s1_reg <= {ck_i, cs_b_i, ras_b_i, cas_b_i, we_b_i, ba_i, addr_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        pin_reg <= s3_reg;
      end
      ck_d_reg <= pin_reg.ck;
    end
  end

  // decode of control pins
  function automatic lsa_cmd_t decode(input lsa_pins_t p);
    if (p.cs_b) begin
      return CMD_NOP;
    end
    unique case ({p.ras_b, p.cas_b, p.we_b})
      3'b000: return CMD_LMR;
      3'b001: return CMD_REF;
      3'b010: return CMD_PRE;
      3'b011: return CMD_ACT;
      3'b100: return CMD_WRITE;
      3'b101: return CMD_READ;
      3'b110: return CMD_BST;
      3'b111: return CMD_NOP;
    endcase
  endfunction

  assign rise = pin_reg.ck && !ck_d_reg;
  assign fall = !pin_reg.ck && ck_d_reg;
  assign cmd = rise ? decode(pin_reg) : CMD_NOP;

  // ---------------------------------------------------------------
  // mode registers
  // ---------------------------------------------------------------
  logic [2:0] cl_reg, bl_reg, partial_array_refresh_select_reg;
  logic [1:0] ds_reg;
  logic srr_arm_reg;
  logic [3:0] temp_reg;
  logic [4:0] bl_len;

  // latency kept to two or three, extended bits retained
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cl_reg <= CL_RST;
      bl_reg <= BL_RST;
      partial_array_refresh_select_reg <= PARTIAL_ARRAY_REFRESH_SELECT_RST;
      ds_reg <= DS_RST;
    end else if (cmd == CMD_LMR && pin_reg.ba == BA_MR) begin
      cl_reg <= (pin_reg.addr[MR_CL_LSB +: 3] == 3'h2) ? 3'h2 : 3'h3; // see RULE23
      bl_reg <= pin_reg.addr[MR_BL_LSB +: 3];
    end else if (cmd == CMD_LMR && pin_reg.ba == BA_EMR) begin
      partial_array_refresh_select_reg <= pin_reg.addr[EMR_PARTIAL_ARRAY_REFRESH_SELECT_LSB +: 3]; // see RULE24
      ds_reg <= pin_reg.addr[EMR_DS_LSB +: 2]; // see RULE24
    end
  end

  // burst length from mode code, two when code unknown
  always_comb begin
    unique case (bl_reg)
      3'h2: bl_len = 5'h04;
      3'h3: bl_len = 5'h08;
      3'h4: bl_len = 5'h10;
      default: bl_len = 5'h02;
    endcase
  end

  // status read armed by lmr select, used by the next read
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      srr_arm_reg <= 1'b0;
    end else if (cmd == CMD_LMR) begin
      srr_arm_reg <= (pin_reg.ba == BA_SRR); // see RULE5
    end else if (cmd == CMD_READ) begin
      srr_arm_reg <= 1'b0;
    end
  end

  // self refresh region, pacing and drive impedance
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sref_bank_o <= 4'hf;
      sref_row_zero_o <= 2'h0;
      sref_rate_o <= TEMP_RST;
      drive_ohms_o <= OHM_FULL;
    end else begin
      unique case (partial_array_refresh_select_reg) // see RULE2
        3'h1: {sref_bank_o, sref_row_zero_o} <= {4'h3, 2'h0};
        3'h2: {sref_bank_o, sref_row_zero_o} <= {4'h1, 2'h0};
        3'h5: {sref_bank_o, sref_row_zero_o} <= {4'h1, 2'h1};
        3'h6: {sref_bank_o, sref_row_zero_o} <= {4'h1, 2'h3};
        default: {sref_bank_o, sref_row_zero_o} <= {4'hf, 2'h0};
      endcase
      sref_rate_o <= temp_reg; // see RULE1
      unique case (ds_reg) // see RULE4
        2'h1: drive_ohms_o <= OHM_3Q;
        2'h2: drive_ohms_o <= OHM_HALF;
        default: drive_ohms_o <= OHM_FULL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bank state
  // ---------------------------------------------------------------
  logic [3:0] open_reg;
  logic [9:0] row_reg [4];
  logic ap_done;
  logic [1:0] ap_bank;

  // open on activate, close on precharge or auto precharge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      open_reg <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        row_reg[i] <= 10'h000;
      end
    end else begin
      if (ap_done) begin
        open_reg[ap_bank] <= 1'b0; // see RULE15
      end
      if (cmd == CMD_ACT) begin
        open_reg[pin_reg.ba] <= 1'b1;
        row_reg[pin_reg.ba] <= pin_reg.addr[9:0];
      end else if (cmd == CMD_PRE && pin_reg.addr[10]) begin
        open_reg <= 4'h0;
      end else if (cmd == CMD_PRE) begin
        open_reg[pin_reg.ba] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // latency pipe, one slot per ck cycle
  // ---------------------------------------------------------------
  lsa_ent_t pipe_reg [PIPE_N];
  lsa_ent_t new_ent, go_ent, pre_ent;

  // reads and stops enter, stops take the read latency
  always_comb begin
    new_ent = '0;
    new_ent.bank = pin_reg.ba;
    new_ent.col = pin_reg.addr[3:0];
    new_ent.ap = pin_reg.addr[10];
    new_ent.status_read_word = srr_arm_reg;
    new_ent.len = srr_arm_reg ? SRR_LEN : bl_len; // see RULE9
    new_ent.vld = (cmd == CMD_READ);
    new_ent.stop = (cmd == CMD_BST) || (cmd == CMD_PRE); // see RULE20
    new_ent.all_bk = (cmd == CMD_BST) || pin_reg.addr[10];
  end

  assign go_ent = pipe_reg[cl_reg[1:0] - 2'h1];
  assign pre_ent = pipe_reg[cl_reg[1:0] - 2'h2];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < PIPE_N; i++) begin
        pipe_reg[i] <= '0;
      end
    end else if (rise) begin
      pipe_reg[0] <= new_ent;
      for (int i = 1; i < PIPE_N; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // read burst engine, one element per ck edge
  // ---------------------------------------------------------------
  lsa_ent_t cur_reg;
  logic [4:0] beat_reg;
  logic [15:0] stat_word;
  logic start, cut, done, in_burst;

  // word for one element, sequential order within the block
  function automatic logic [15:0] elem(input lsa_ent_t e,
      input logic [4:0] b, input logic [9:0] row, input logic [15:0] sw);
    logic [3:0] m;
    logic [3:0] c;
    m = e.len[3:0] - 4'h1;
    c = (e.col & ~m) | ((e.col + b[3:0]) & m);
    if (e.status_read_word) begin
      return (b == 5'h00) ? sw : 16'h0000;
    end
    return {e.bank, row, c};
  endfunction

  assign stat_word = {MAKER_ID, REV_ID, temp_reg, 1'b0, DENSITY}; // see RULE10
  assign in_burst = dq_oe_o && (beat_reg != cur_reg.len);
  assign start = rise && go_ent.vld;
  assign cut = rise && go_ent.stop &&
      (go_ent.all_bk || go_ent.bank == cur_reg.bank); // see RULE18
  assign done = rise && dq_oe_o && beat_reg == cur_reg.len;
  assign ap_done = done && !start && cur_reg.ap;
  assign ap_bank = cur_reg.bank;

  // start, carry on, truncate or end a burst
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cur_reg <= '0;
      beat_reg <= 5'h00;
      dq_o <= 16'h0000;
      dq_oe_o <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe_o <= 1'b0;
    end else if (cmd == CMD_WRITE) begin
      dq_oe_o <= 1'b0; // see RULE18
      dqs_oe_o <= 1'b0;
    end else if (start) begin
      cur_reg <= go_ent; // see RULE19
      beat_reg <= 5'h01;
      dq_o <= elem(go_ent, 5'h00, row_reg[go_ent.bank], stat_word); // see RULE3
      dq_oe_o <= 1'b1; // see RULE16
      dqs_o <= 1'b1;
      dqs_oe_o <= 1'b1;
    end else if (cut || done) begin
      dq_oe_o <= 1'b0; // see RULE17
      dqs_o <= 1'b0;
      dqs_oe_o <= rise && pre_ent.vld;
    end else if ((rise || fall) && in_burst) begin
      beat_reg <= beat_reg + 5'h01;
      dq_o <= elem(cur_reg, beat_reg, row_reg[cur_reg.bank], stat_word);
      dqs_o <= rise; // see RULE17
    end else if (rise && pre_ent.vld && !dq_oe_o) begin
      dqs_o <= 1'b0; // see RULE17
      dqs_oe_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_word;
  logic take;

  assign take = hsel_i && htrans_i[1] && hready_i;

  // read mux, unmapped reads give zero
  always_comb begin
    unique case (haddr_i[7:0])
      REG_MODE: rd_word = {25'h0, cl_reg, 1'b0, bl_reg};
      REG_EXT: rd_word = {25'h0, ds_reg, 2'h0, partial_array_refresh_select_reg};
      REG_TEMP: rd_word = {28'h0, temp_reg};
      REG_BANK: rd_word = {23'h0, srr_arm_reg, 3'h0, dq_oe_o, open_reg};
      REG_STAT: rd_word = {16'h0, stat_word};
      default: rd_word = 32'h0;
    endcase
  end

  // address phase capture and read data
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      wr_pend_reg <= take && hwrite_i && haddr_i[31:8] == 24'h0;
      wr_addr_reg <= haddr_i[7:0];
      if (take && !hwrite_i) begin
        hrdata_o <= (haddr_i[31:8] == 24'h0) ? rd_word : 32'h0;
      end
    end
  end

  // temperature sensor reading, written by software
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      temp_reg <= TEMP_RST;
    end else if (wr_pend_reg && wr_addr_reg == REG_TEMP) begin
      temp_reg <= hwdata_i[3:0];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence ds_steady(logic [1:0] c);
    ds_reg == c ##1 ds_reg == c;
  endsequence

  a_drive_three: assert property (ds_steady(2'h1) |=> drive_ohms_o == OHM_3Q) // see RULE4
    else $error("drive impedance not 37 ohm");
  a_partial_array_refresh_select_quarter: assert property (partial_array_refresh_select_reg == 3'h2 ##1 partial_array_refresh_select_reg == 3'h2 // see RULE2
    |=> sref_bank_o == 4'h1 && sref_row_zero_o == 2'h0)
    else $error("quarter region wrong");
  a_temp_comp_refresh_setting_ignore: assert property (cmd == CMD_LMR && pin_reg.ba == BA_EMR // see RULE1
    |=> $stable(temp_reg))
    else $error("refresh rate moved by mode load");
  a_srr_two: assert property (start && go_ent.status_read_word |=> cur_reg.len == SRR_LEN) // see RULE9
    else $error("status burst not two");
  a_stat_read: assert property (take && !hwrite_i && haddr_i == 32'h10 // see RULE10
    |=> hrdata_o[15:0] == $past(stat_word))
    else $error("status word read wrong");
  a_first_beat: assert property (start && cmd != CMD_WRITE // see RULE16
    |=> dq_oe_o && dqs_o && beat_reg == 5'h01)
    else $error("first element missing");
  a_preamble_low: assert property (dqs_oe_o && !dq_oe_o |-> !dqs_o) // see RULE17
    else $error("strobe high outside data");
  a_float_end: assert property (done && !start && cmd != CMD_WRITE // see RULE17
    |=> !dq_oe_o)
    else $error("data not floated at end");
  a_stop_cut: assert property (cut && !start |=> !dq_oe_o) // see RULE20
    else $error("stop did not end burst");
  a_auto_pre: assert property (ap_done && cmd != CMD_ACT // see RULE15
    |=> !open_reg[$past(ap_bank)])
    else $error("auto precharge missed");
  a_latency_set: assert property (cmd == CMD_LMR // see RULE23
    && pin_reg.ba == BA_MR && pin_reg.addr[MR_CL_LSB +: 3] == 3'h2
    |=> cl_reg == 3'h2)
    else $error("latency out of range");
endmodule
`default_nettype wire

// ---- tb/lsa_ctl_model.sv ----
// controller model: drives dram command pins, logs the data wire
// assumes a free running 200 ns ck, phase unrelated to clk_i
`timescale 1ns/1ps
`default_nettype none
module lsa_ctl_model import lsa_pkg::*; (
  // command pins
  output var lsa_pins_t pins_o,
  // data pins from the device
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic dqs_i,
  input wire logic dqs_oe_i,
  // resolved wire levels
  output logic [15:0] dq_w_o,
  output logic dqs_w_o
);
  int hc = 0;
  logic ck = 1'b0;
  realtime t_end = -1.0;
  logic [18:0] lg [0:4095];
  // ---------------------------------------------------------------
  // link clock and wire log
  // ---------------------------------------------------------------
  // ck runs free, pins start as nop
  initial begin
    pins_o = '{ck: 1'b0, cs_b: 1'b0, ras_b: 1'b1, cas_b: 1'b1,
               we_b: 1'b1, ba: 2'h0, addr: 13'h0000};
    #7;
    forever begin
      #100;
      ck = ~ck;
      pins_o.ck = ck;
    end
  end
  // state launched by each edge, sampled late in its window
  always @(ck) begin
    hc = hc + 1;
    #80 lg[hc - 1] = {dq_oe_i, dqs_oe_i, dqs_i, dq_i};
  end
  // released lines toggle instead of holding the last value
  assign dq_w_o = dq_oe_i ? dq_i : {16{hc[0]}};
  assign dqs_w_o = dqs_oe_i ? dqs_i : hc[0];
  // ---------------------------------------------------------------
  // command issue
  // ---------------------------------------------------------------
  // pins change 40 ns before a rise and hold 160 ns after it
  task automatic cmd(input lsa_cmd_t k, input logic [1:0] b,
                     input logic [12:0] a, output int r);
    logic [2:0] c;
    case (k)
      CMD_LMR: c = 3'b000;
      CMD_ACT: c = 3'b011;
      CMD_READ: c = 3'b101;
      CMD_WRITE: c = 3'b100;
      CMD_PRE: c = 3'b010;
      CMD_BST: c = 3'b110;
      CMD_REF: c = 3'b001;
      default: c = 3'b111;
    endcase
    if ($realtime != t_end) begin
      @(negedge ck);
      #60;
    end
    {pins_o.ras_b, pins_o.cas_b, pins_o.we_b} = c;
    pins_o.ba = b;
    pins_o.addr = a;
    @(posedge ck);
    #1;
    r = hc;
    @(negedge ck);
    #60;
    t_end = $realtime;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the dram command block
// assumes lsa_ctl_model issues commands on its own 200 ns ck
`timescale 1ns/1ps
`default_nettype none
module tb_top import lsa_pkg::*; ();
  localparam logic [3:0] MAKER = 4'h9; // arbitrary value
  localparam logic [3:0] REV = 4'h2; // arbitrary value
  localparam logic [2:0] DENS = 3'h3;
  localparam logic [9:0] ROW = 10'h155;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_T [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  localparam logic [3:0] BANK_T [5] = '{4'hf, 4'h3, 4'h1, 4'h1, 4'h1};
  localparam logic [1:0] ROWZ_T [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
  localparam logic [5:0] OHM_T [5] = '{OHM_FULL, OHM_3Q, OHM_HALF,
                                        OHM_FULL, OHM_FULL};
  localparam lsa_cmd_t CUT_T [4] = '{CMD_READ, CMD_BST, CMD_WRITE,
                                      CMD_PRE};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, dq_oe, dqs, dqs_oe, dqs_w;
  logic [31:0] hrdata, rdv;
  lsa_pins_t pins;
  logic [15:0] dq, dq_w;
  logic [3:0] sref_bank, sref_rate;
  logic [1:0] row_zero;
  logic [5:0] ohms;
  logic [15:0] exp_q [$];
  int err_total = 0;
  int samples_checked = 0;
  int rr, r0;
  // ---------------------------------------------------------------
  // design and controller
  // ---------------------------------------------------------------
  lsa_dram #(.MAKER_ID(MAKER), .REV_ID(REV), .DENSITY(DENS)) i_dut (
    .clk_i(clk), .rst_b_i(rst_b), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .ck_i(pins.ck),
    .cs_b_i(pins.cs_b), .ras_b_i(pins.ras_b), .cas_b_i(pins.cas_b),
    .we_b_i(pins.we_b), .ba_i(pins.ba), .addr_i(pins.addr),
    .dq_i(dq_w), .dq_o(dq), .dq_oe_o(dq_oe), .dqs_i(dqs_w),
    .dqs_o(dqs), .dqs_oe_o(dqs_oe), .sref_bank_o(sref_bank),
    .sref_row_zero_o(row_zero), .sref_rate_o(sref_rate),
    .drive_ohms_o(ohms));
  lsa_ctl_model i_ctrl (.pins_o(pins), .dq_i(dq), .dq_oe_i(dq_oe),
    .dqs_i(dqs), .dqs_oe_i(dqs_oe), .dq_w_o(dq_w), .dqs_w_o(dqs_w));
  // system clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      err_total = err_total + 1;
      stop_test();
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    ahb(1'b1, {24'h0, o}, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] o,
                     input logic [31:0] e);
    ahb(1'b0, {24'h0, o}, 32'h0);
    chk(nm, e, rdv);
  endtask
  task automatic go(input lsa_cmd_t k, input logic [1:0] b,
                    input logic [12:0] a);
    i_ctrl.cmd(k, b, a, rr);
  endtask
  task automatic idle(input int n);
    repeat (n) go(CMD_NOP, 2'h0, 13'h0);
  endtask
  function automatic logic [15:0] el(input logic [1:0] b, input int c);
    return {b, ROW, c[3:0]};
  endfunction
  task automatic add(input logic [1:0] b, input int c, input int n);
    for (int j = 0; j < n; j++) exp_q.push_back(el(b, c + j));
  endtask
  // wire log against preamble, elements in pairs, release
  task automatic chk_burst(input string nm, input int r, input int cl);
    int b;
    logic [18:0] g;
    b = r + 2 * cl;
    idle(10);
    g = i_ctrl.lg[b - 2];
    chk({nm, " preamble"}, 32'h2, {29'h0, g[18:16]});
    foreach (exp_q[j]) begin
      g = i_ctrl.lg[b + j];
      chk(nm, {13'h0, 2'h3, ~j[0], exp_q[j]}, {13'h0, g});
    end
    g = i_ctrl.lg[b + exp_q.size()];
    chk({nm, " release"}, 32'h0, {30'h0, g[18:17]});
    exp_q.delete();
    $display("test %s done", nm);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rdc("mode", REG_MODE, {25'h0, CL_RST, 1'b0, BL_RST});
    wr(REG_MODE, 32'hffff_ffff);
    rdc("mode ro", REG_MODE, {25'h0, CL_RST, 1'b0, BL_RST});
    rdc("ext", REG_EXT, {25'h0, DS_RST, 2'h0, PARTIAL_ARRAY_REFRESH_SELECT_RST});
    rdc("unmapped", 8'h40, 32'h0);
    ahb(1'b0, 32'h0000_0110, 32'h0);
    chk("high addr", 32'h0, rdv);
    chk("okay", 32'h0, {31'h0, hresp});
    chk("ohms", {26'h0, OHM_FULL}, {26'h0, ohms});
    rdc("temp", REG_TEMP, {28'h0, TEMP_RST});
    wr(REG_TEMP, 32'h3);
    rdc("temp rw", REG_TEMP, 32'h3);
    ahb(1'b1, 32'h0000_0108, 32'h7);
    rdc("temp high", REG_TEMP, 32'h3);
    chk("rate", 32'h3, {28'h0, sref_rate});
    $display("test registers done");
    idle(2);
    for (int i = 0; i < 5; i++) begin
      go(CMD_LMR, BA_EMR, {6'h0, 2'(i % 4), 2'h3, PARTIAL_ARRAY_REFRESH_SELECT_T[i]});
      idle(2);
      rdc("ext", REG_EXT, {25'h0, 2'(i % 4), 2'h0, PARTIAL_ARRAY_REFRESH_SELECT_T[i]});
      chk("bank", {28'h0, BANK_T[i]}, {28'h0, sref_bank});
      chk("rowz", {30'h0, ROWZ_T[i]}, {30'h0, row_zero});
      chk("ohms", {26'h0, OHM_T[i]}, {26'h0, ohms});
      chk("rate", 32'h3, {28'h0, sref_rate});
    end
    go(CMD_ACT, 2'h1, {3'h0, ROW});
    idle(2);
    rdc("open", REG_BANK, 32'h2);
    go(CMD_READ, 2'h1, 13'h6);
    r0 = rr;
    add(1, 6, 2);
    add(1, 4, 2);
    chk_burst("wrap", r0, 3);
    go(CMD_READ, 2'h1, 13'h0);
    r0 = rr;
    idle(1);
    go(CMD_READ, 2'h1, 13'h8);
    add(1, 0, 4);
    add(1, 8, 4);
    chk_burst("concat", r0, 3);
    for (int i = 0; i < 4; i++) begin
      go(CMD_READ, 2'h1, 13'h0);
      r0 = rr;
      if (i == 2) begin
        go(CMD_BST, 2'h1, 13'h0);
        idle(2);
      end
      go(CUT_T[i], 2'h1, 13'h4);
      add(1, 0, 2);
      if (i == 0) add(1, 4, 4);
      chk_burst("cut", r0, 3);
    end
    rdc("closed", REG_BANK, 32'h0);
    go(CMD_ACT, 2'h1, {3'h0, ROW});
    idle(2);
    go(CMD_ACT, 2'h2, {3'h0, ROW});
    idle(2);
    rdc("open", REG_BANK, 32'h6);
    go(CMD_READ, 2'h1, 13'h400);
    r0 = rr;
    add(1, 0, 4);
    chk_burst("auto close", r0, 3);
    rdc("open", REG_BANK, 32'h4);
    go(CMD_PRE, 2'h0, 13'h400);
    idle(2);
    go(CMD_LMR, BA_SRR, 13'h0);
    idle(2);
    go(CMD_READ, 2'h0, 13'h0);
    r0 = rr;
    exp_q.push_back({MAKER, REV, 4'h3, 1'b0, DENS});
    exp_q.push_back(16'h0);
    chk_burst("status", r0, 3);
    rdc("stat", REG_STAT, {16'h0, MAKER, REV, 4'h3, 1'b0, DENS});
    chk("refresh mult", 32'h3, {28'h0, rdv[7:4]});
    go(CMD_LMR, BA_MR, 13'h021);
    idle(2);
    rdc("mode", REG_MODE, 32'h21);
    go(CMD_ACT, 2'h3, {3'h0, ROW});
    idle(2);
    go(CMD_READ, 2'h3, 13'h5);
    r0 = rr;
    add(3, 5, 1);
    add(3, 4, 1);
    chk_burst("short", r0, 2);
    stop_test();
  end
endmodule
`default_nettype wire
